/* File: rtl/lle_exec.sv */
// load-linked word and doubleword execution unit
`timescale 1ns/100ps
`include "lle_cfg.svh"
module lle_exec
    import lle_pkg::*;
#(
    parameter int XLEN    = `LLE_XLEN,
    parameter int TIMEOUT = `LLE_MEM_TIMEOUT
) (
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_resetn,
    // issue
    input  wire logic              i_issue,
    input  wire logic              i_is_dword,
    input  wire logic              i_opcode_valid,
    input  wire logic [4:0]        i_target_register_field,
    input  wire logic [XLEN-1:0]   i_base_value,
    input  wire logic [15:0]       i_offset,
    input  wire logic              i_big_endian_indicator,
    // translation and watch status for the issued address
    input  wire logic              i_tlb_refill,
    input  wire logic              i_tlb_invalid,
    input  wire logic              i_watch_hit,
    // memory read port
    output logic                   o_mem_req,
    output logic      [XLEN-1:0]   o_mem_addr,
    output logic                   o_mem_dword,
    input  wire logic              i_mem_ack,
    input  wire logic [XLEN-1:0]   i_mem_data,
    // store-conditional closing
    input  wire logic              i_sc_done,
    // writeback and status
    output logic                   o_wb_valid,
    output logic      [4:0]        o_wb_reg,
    output logic      [XLEN-1:0]   o_wb_data,
    output logic                   o_exc_valid,
    output lle_pkg::lle_exc_t      o_exc_code,
    output logic                   o_busy,
    output logic                   o_link_flag
);
    import lle_pkg::*;

    typedef struct packed {
        lle_state_t      state;
        logic            mem_req;
        logic [XLEN-1:0] addr;
        logic            dword;
        logic [4:0]      rt;
        logic            wb_pend;
        logic            wb_valid;
        logic            exc_valid;
        lle_exc_t        exc_code;
        logic            link;
        logic            busy;
        logic [XLEN-1:0] wb_data;
    } lle_st_t;

    lle_st_t          st_r;
    lle_st_t          st_nxt;
    logic [XLEN-1:0]  eff_addr;
    logic             misalign;
    logic             capture;
    logic [XLEN-1:0]  lane_result;

    assign eff_addr = i_base_value + {{(XLEN-16){i_offset[15]}}, i_offset};
    assign misalign = i_is_dword ? (eff_addr[`LLE_DWORD_ALIGN_W-1:0] != 3'h0)
                                 : (eff_addr[`LLE_WORD_ALIGN_W-1:0] != 2'h0);
    assign capture  = (st_r.state == LLE_ST_WAIT) && i_mem_ack;

    always_comb begin
        st_nxt           = st_r;
        st_nxt.wb_valid  = 1'b0;
        st_nxt.exc_valid = 1'b0;
        st_nxt.exc_code  = LLE_EXC_NONE;
        // closing a sequence first; a load in the same cycle opens a new one
        if (i_sc_done) begin
            st_nxt.link = 1'b0;
        end
        unique case (st_r.state)
            LLE_ST_IDLE: begin
                if (i_issue) begin
                    st_nxt.exc_valid = 1'b1;
                    // priority: reserved, tlb refill, tlb invalid, address, watch
                    if (!i_opcode_valid) begin
                        st_nxt.exc_code = LLE_EXC_RSVD_INSN;
                    end else if (i_tlb_refill) begin
                        st_nxt.exc_code = LLE_EXC_TLB_REFIL;
                    end else if (i_tlb_invalid) begin
                        st_nxt.exc_code = LLE_EXC_TLB_INVAL;
                    end else if (misalign) begin
                        st_nxt.exc_code = LLE_EXC_ADDR_ERR;
                    end else if (i_watch_hit) begin
                        st_nxt.exc_code = LLE_EXC_WATCH;
                    end else begin
                        st_nxt.exc_valid = 1'b0;
                        st_nxt.state     = LLE_ST_WAIT;
                        st_nxt.mem_req   = 1'b1;
                        st_nxt.addr      = eff_addr;
                        st_nxt.dword     = i_is_dword;
                        st_nxt.rt        = i_target_register_field;
                        st_nxt.busy      = 1'b1;
                    end
                end
            end
            LLE_ST_WAIT: begin
                if (i_mem_ack) begin
                    st_nxt.mem_req = 1'b0;
                    st_nxt.wb_pend = 1'b1;
                    st_nxt.busy    = 1'b0;
                    st_nxt.state   = LLE_ST_IDLE;
                    // plain local flag: no bus action reaches other processors
                    st_nxt.link    = 1'b1;
                end
            end
            default: begin
                st_nxt.state   = LLE_ST_IDLE;
                st_nxt.mem_req = 1'b0;
                st_nxt.busy    = 1'b0;
            end
        endcase
        if (st_r.wb_pend) begin
            st_nxt.wb_pend  = 1'b0;
            st_nxt.wb_valid = 1'b1;
            st_nxt.wb_data  = lane_result;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_r          <= '0;
            st_r.state    <= LLE_ST_IDLE;
            st_r.exc_code <= LLE_EXC_NONE;
            st_r.link     <= `LLE_LINK_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    lle_lane_sel #(
        .XLEN                   (XLEN)
    ) u_lane (
        .i_clk                  (i_clk),
        .i_resetn               (i_resetn),
        .i_load                 (capture),
        .i_is_dword             (st_r.dword),
        .i_vaddr_lo             (st_r.addr[2:0]),
        .i_big_endian_indicator (i_big_endian_indicator),
        .i_mem_data             (i_mem_data),
        .o_result               (lane_result)
    );

    // abandoned sequences just leave the flag set; nothing to clean up
    assign o_wb_data   = st_r.wb_data;
    assign o_mem_req   = st_r.mem_req;
    assign o_mem_addr  = st_r.addr;
    assign o_mem_dword = st_r.dword;
    assign o_wb_valid  = st_r.wb_valid;
    assign o_wb_reg    = st_r.rt;
    assign o_exc_valid = st_r.exc_valid;
    assign o_exc_code  = st_r.exc_code;
    // own flop so the busy output carries no compare logic
    assign o_busy      = st_r.busy;
    assign o_link_flag = st_r.link;

    sequence s_ack;
        (st_r.state == LLE_ST_WAIT) && i_mem_ack;
    endsequence
    sequence s_wb;
        ##2 o_wb_valid;
    endsequence

    AST_ADDR_ERR_W: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_issue && !o_busy && i_opcode_valid && !i_tlb_refill && !i_tlb_invalid && !i_is_dword
         && eff_addr[1:0] != 2'h0) |=> (o_exc_valid && o_exc_code == LLE_EXC_ADDR_ERR && !o_mem_req))
        else $error("word misalign not flagged");
    AST_ADDR_ERR_D: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_issue && !o_busy && i_opcode_valid && !i_tlb_refill && !i_tlb_invalid && i_is_dword
         && eff_addr[2:0] != 3'h0) |=> (o_exc_valid && o_exc_code == LLE_EXC_ADDR_ERR))
        else $error("dword misalign not flagged");
    AST_EA: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_issue && !o_busy && !misalign && i_opcode_valid && !i_tlb_refill && !i_tlb_invalid
         && !i_watch_hit) |=> (o_mem_req && o_mem_addr == $past(eff_addr)))
        else $error("effective address wrong");
    AST_LINK_SET: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_ack |=> o_link_flag)
        else $error("link flag not set");
    AST_WB_TIMING: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_ack |-> s_wb)
        else $error("writeback missing");
    AST_DWORD_DATA: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (s_ack and st_r.dword) |-> ##2 (o_wb_data == $past(i_mem_data, 2)))
        else $error("dword data altered");
    AST_WORD_SEXT: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_wb_valid && !$past(st_r.dword, 2) |-> (o_wb_data[XLEN-1:32] == {(XLEN-32){o_wb_data[31]}}))
        else $error("word not sign extended");
    AST_LINK_CLR: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_sc_done && !capture) |=> !o_link_flag)
        else $error("link flag not cleared");
    AST_BUSY_DROP: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_ack |=> !o_busy)
        else $error("busy not released after answer");
    AST_RSVD_NO_REQ: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_issue && !o_busy && !i_opcode_valid) |=> (o_exc_valid && o_exc_code == LLE_EXC_RSVD_INSN && !o_mem_req))
        else $error("reserved instruction not flagged");
    AST_EXC_KEEPS_LINK: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_issue && !o_busy && !i_opcode_valid && !i_sc_done) |=> (o_link_flag == $past(o_link_flag)))
        else $error("faulted load touched link flag");
    AST_NO_EXC_OK: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_ack |=> !o_exc_valid)
        else $error("spurious exception");
endmodule

/* File: rtl/lle_cfg.svh */
// constants for the load-linked execution block
`ifndef LLE_CFG_SVH
`define LLE_CFG_SVH
`define LLE_XLEN          64
`define LLE_IMM_W         16
`define LLE_WORD_W        32
`define LLE_WORD_ALIGN_W  2
`define LLE_DWORD_ALIGN_W 3
`define LLE_LANE_W        3
`define LLE_LINK_RST      1'b0
`define LLE_MEM_TIMEOUT   16
`endif

/* File: rtl/lle_pkg.sv */
// types for the load-linked execution block
package lle_pkg;
    typedef enum logic [1:0] {
        LLE_ST_IDLE = 2'b00,
        LLE_ST_WAIT = 2'b01
    } lle_state_t;

    typedef enum logic [2:0] {
        LLE_EXC_NONE      = 3'b000,
        LLE_EXC_TLB_REFIL = 3'b001,
        LLE_EXC_TLB_INVAL = 3'b010,
        LLE_EXC_ADDR_ERR  = 3'b011,
        LLE_EXC_RSVD_INSN = 3'b100,
        LLE_EXC_WATCH     = 3'b101
    } lle_exc_t;
endpackage

/* File: rtl/lle_lane_sel.sv */
// byte-lane selection and extension of loaded data
`timescale 1ns/100ps
`include "lle_cfg.svh"
module lle_lane_sel #(
    parameter int XLEN = `LLE_XLEN
) (
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_resetn,
    // capture request
    input  wire logic              i_load,
    input  wire logic              i_is_dword,
    input  wire logic [2:0]        i_vaddr_lo,
    input  wire logic              i_big_endian_indicator,
    input  wire logic [XLEN-1:0]   i_mem_data,
    // result
    output logic      [XLEN-1:0]   o_result
);
    typedef struct packed {
        logic [XLEN-1:0] result;
    } lle_lane_st_t;

    lle_lane_st_t st_r;
    lle_lane_st_t st_nxt;
    logic [2:0]   lane;
    logic [31:0]  word;

    always_comb begin
        st_nxt = st_r;
        // big-endian flips only bit 2 of the lane index
        lane = i_vaddr_lo ^ {i_big_endian_indicator, 2'b00};
        word = i_mem_data[{lane[2], 5'b00000} +: 32];
        if (i_load) begin
            if (i_is_dword) begin
                st_nxt.result = i_mem_data;
            end else begin
                // sign extension only; no unsigned variant exists
                st_nxt.result = {{(XLEN-32){word[31]}}, word};
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_result = st_r.result;
endmodule

/* File: verification/lle_mem_model.sv */
// partner model: shared memory answering aligned doubleword reads
`timescale 1ns/100ps
module lle_mem_model (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    // read request from the core
    input  wire logic        i_req,
    input  wire logic [63:0] i_addr,
    input  wire logic [3:0]  i_delay,
    // answer
    output logic             o_ack,
    output logic      [63:0] o_data
);
    logic [3:0]  cnt_r;
    logic [31:0] al;
    assign al = {i_addr[31:3], 3'b000};
    // every location treated as synchronizable; stall length set by i_delay
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_r  <= 4'h0;
            o_ack  <= 1'b0;
            o_data <= 64'h0;
        end else begin
            o_ack  <= 1'b0;
            // released bus never keeps the last value
            o_data <= ~o_data;
            if (i_req && !o_ack) begin
                cnt_r <= (cnt_r == i_delay) ? 4'h0 : cnt_r + 4'h1;
                if (cnt_r == i_delay) begin
                    o_ack  <= 1'b1;
                    o_data <= {al ^ 32'h9e37_79b9, al ^ 32'h7f4a_7c15};
                end
            end
        end
    end
endmodule

/* File: verification/lle_exec_bench.sv */
// self-checking bench for the load-linked execution unit
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module lle_exec_bench;
    import lle_pkg::*;
    logic        clk, resetn, issue, dw, opv, be, refill, inval, watch, sc;
    logic        mreq, mdw, ack, wbv, excv, busy, link, saw_req, got_exc;
    logic [4:0]  tgt, wbr, got_r;
    logic [63:0] base, maddr, mdata, wbd, got_d;
    logic [65:0] got_a;
    logic [15:0] off;
    logic [3:0]  dly;
    lle_exc_t    exc, got_c;
    int          fail_count, n_checks, cyc, nwb;

    lle_exec DUT (.i_clk(clk), .i_resetn(resetn), .i_issue(issue), .i_is_dword(dw),
        .i_opcode_valid(opv), .i_target_register_field(tgt), .i_base_value(base), .i_offset(off),
        .i_big_endian_indicator(be), .i_tlb_refill(refill), .i_tlb_invalid(inval), .i_watch_hit(watch),
        .o_mem_req(mreq), .o_mem_addr(maddr), .o_mem_dword(mdw), .i_mem_ack(ack), .i_mem_data(mdata),
        .i_sc_done(sc), .o_wb_valid(wbv), .o_wb_reg(wbr), .o_wb_data(wbd), .o_exc_valid(excv),
        .o_exc_code(exc), .o_busy(busy), .o_link_flag(link));
    lle_mem_model MEM (.i_clk(clk), .i_resetn(resetn), .i_req(mreq), .i_addr(maddr),
        .i_delay(dly), .o_ack(ack), .o_data(mdata));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ceiling well above the roughly 140 cycles the scenarios need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            report_and_stop();
        end
    end

    task report_and_stop;
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // expected word: lane picked by low address bits, endian flips bit 2
    function automatic logic [63:0] expw(input logic [63:0] a, input logic e);
        logic [31:0] al;
        logic [63:0] d;
        logic [2:0]  l;
        al = {a[31:3], 3'b000};
        d = {al ^ 32'h9e37_79b9, al ^ 32'h7f4a_7c15};
        l = a[2:0] ^ {e, 2'b00};
        expw = {{32{d[8*l+31]}}, d[8*l+:32]};
    endfunction

    // issue one load-linked; again re-issues while busy, which must be ignored
    task run(input logic d, input logic [63:0] b, input logic [15:0] o, input logic again);
        @(negedge clk);
        issue = 1'b1; dw = d; base = b; off = o; tgt = tgt + 5'h1;
        saw_req = 1'b0; got_exc = 1'b0; nwb = 0; got_d = 'x; got_a = 'x;
        for (int k = 0; k < 40 && !got_exc && nwb == 0; k++) begin
            @(negedge clk);
            issue = (k == 1) && again;
            // the ignored re-issue names another target, so a wrong take shows up
            if ((k == 1) && again) tgt = tgt + 5'h1;
            saw_req |= (mreq === 1'b1);
            if (mreq === 1'b1) got_a = {busy, mdw, maddr};
            if (excv === 1'b1) begin got_exc = 1'b1; got_c = exc; end
            if (wbv === 1'b1) begin nwb++; got_d = wbd; got_r = wbr; end
        end
        repeat (4) begin @(negedge clk); nwb += (wbv === 1'b1); end
    endtask

    task t_reset;
        `CHK({mreq, wbv, excv, busy, link}, 5'h0)
        `CHK(exc, LLE_EXC_NONE)
    endtask

    // both lanes, both byte orders; the second load replaces a live sequence
    task t_word;
        for (int e = 0; e < 2; e++)
            for (int k = 0; k < 2; k++) begin
                be = e[0];
                run(1'b0, 64'h8000_1010 + 64'(4 * k), 16'hfff8, 1'b0);
                `CHK(got_exc, 1'b0)
                `CHK(got_d, expw(64'h8000_1008 + 64'(4 * k), e[0]))
                `CHK(got_r, tgt)
                `CHK(got_a, {2'b10, 64'h8000_1008 + 64'(4 * k)})
                `CHK(link, 1'b1)
            end
        @(negedge clk); sc = 1'b1;
        @(negedge clk); sc = 1'b0;
        `CHK(link, 1'b0)
    endtask

    task t_align;
        for (int j = 1; j < 8; j++) begin
            run(1'b1, 64'h100 + 64'(j), 16'h0, 1'b0);
            `CHK({got_exc, got_c, saw_req, link}, {1'b1, LLE_EXC_ADDR_ERR, 2'b00})
            if (j < 4) begin
                run(1'b0, 64'h100 + 64'(j), 16'h0, 1'b0);
                `CHK({got_exc, got_c, saw_req, link}, {1'b1, LLE_EXC_ADDR_ERR, 2'b00})
            end
        end
    endtask

    // reserved wins over a misaligned address; refill, invalid and watch each raised alone
    task automatic t_exc;
        lle_exc_t tab [4] = '{LLE_EXC_RSVD_INSN, LLE_EXC_TLB_REFIL, LLE_EXC_TLB_INVAL, LLE_EXC_WATCH};
        for (int i = 0; i < 4; i++) begin
            opv = (i != 0); refill = (i == 1); inval = (i == 2); watch = (i == 3);
            run(1'b0, 64'h200 + 64'(i == 0), 16'h0, 1'b0);
            `CHK({got_exc, got_c, saw_req, link}, {1'b1, tab[i], 2'b00})
        end
        opv = 1'b1; watch = 1'b0;
    endtask

    // slow memory, address wraps past zero, second issue while busy
    task t_dword;
        dly = 4'h6;
        run(1'b1, 64'hffff_ffff_ffff_fff0, 16'h0018, 1'b1);
        `CHK(got_d, {32'h9e37_79b1, 32'h7f4a_7c1d})
        `CHK(got_r, tgt - 5'h1)
        `CHK(got_a, {2'b11, 64'h8})
        `CHK(nwb, 1)
        `CHK({got_exc, link}, 2'b01)
    endtask

    initial begin
        {issue, dw, be, refill, inval, watch, sc, resetn} = '0;
        opv = 1'b1; tgt = 5'h0; base = 64'h0; off = 16'h0; dly = 4'h0;
        fail_count = 0; n_checks = 0; cyc = 0;
        repeat (3) @(negedge clk);
        t_reset();
        resetn = 1'b1;
        t_word();
        t_align();
        t_exc();
        t_dword();
        report_and_stop();
    end
endmodule
